/* File: rtl/serial3_pkg.sv */
package serial3_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 4;
  localparam logic [7:0] CTRL_ADDR      = 8'h1A;
  localparam logic [7:0] ASTAT_ADDR     = 8'h1B;
  localparam logic [7:0] AMODE0_ADDR    = 8'h1C;
  localparam logic [7:0] AMODE1_ADDR    = 8'h1D;
  localparam logic [3:0] CTRL_RESET     = 4'h0;
  localparam logic [3:0] ZERO_NIB       = 4'h0;
  localparam int unsigned RUN_BIT       = 3;
  localparam int unsigned PIN_SEL_BIT   = 2;
  localparam int unsigned SEL_HI_BIT    = 1;
  localparam int unsigned SEL_LO_BIT    = 0;
  localparam int unsigned TX_EN_BIT     = 3;
  localparam int unsigned RX_EN_BIT     = 2;
  localparam logic [1:0] CLK_EXT        = 2'h0;
  localparam logic [1:0] CLK_MID        = 2'h1;
  localparam logic [1:0] CLK_FAST       = 2'h2;
  localparam logic [1:0] CLK_SLOW       = 2'h3;
  localparam int unsigned CORE_HZ       = 100000000;
  localparam int unsigned FAST_HZ       = 375000;
  localparam int unsigned MID_MILLIHZ   = 187500000;
  localparam int unsigned SLOW_MILLIHZ  = 46875000;
  // half periods: each enable pulse toggles the shift clock once
  localparam int unsigned FAST_HALF = CORE_HZ / (2 * FAST_HZ);
  localparam int unsigned MID_HALF  = CORE_HZ / (2 * MID_MILLIHZ / 1000);
  localparam int unsigned SLOW_HALF = CORE_HZ / (2 * SLOW_MILLIHZ / 1000);
  localparam int unsigned DIV_W     = 11;
endpackage

/* File: rtl/serial3_rate_div.sv */
`timescale 1ns/10ps
`default_nettype none
module serial3_rate_div
  import serial3_pkg::*;
#(
  parameter int unsigned FAST_CNT = FAST_HALF,
  parameter int unsigned MID_CNT  = MID_HALF,
  parameter int unsigned SLOW_CNT = SLOW_HALF
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            tick
);
  import serial3_pkg::*;
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] limit;
  logic             hit;
  assign limit = (sel == CLK_FAST) ? DIV_W'(FAST_CNT - 1) :
                 (sel == CLK_MID)  ? DIV_W'(MID_CNT - 1)  :
                                     DIV_W'(SLOW_CNT - 1);
  assign hit = (cnt_q >= limit);
  always_ff @(posedge core_clk) begin
    if (reset || !run || sel == CLK_EXT || hit) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (sel != CLK_EXT) && hit;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/serial3_mode_control.sv */
`timescale 1ns/10ps
`default_nettype none
module serial3_mode_control
  import serial3_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clock_stop,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              ext_shift_clk,
  input  wire logic              port_b_bit1_direction,
  input  wire logic              port_b_pin1_latch,
  input  wire logic              serial3_shift_data,
  output logic                   serial3_clocked_active,
  output logic                   serial3_shift_clk,
  output logic                   serial3_shift_edge,
  output logic                   serial3_data_out,
  output logic                   serial3_data_out_oe
);
  import serial3_pkg::*;

  logic [3:0] ctrl_q;
  logic [3:0] amode0_q;
  logic [3:0] amode1_q;
  logic       ext_s1_q;
  logic       ext_s2_q;
  logic       ext_s3_q;
  logic       int_clk_q;
  logic       tick;

  wire serial3_clocked_run    = ctrl_q[RUN_BIT];
  wire serial3_out_pin_select = ctrl_q[PIN_SEL_BIT];
  wire serial3_clock_sel_hi   = ctrl_q[SEL_HI_BIT];
  wire serial3_clock_sel_lo   = ctrl_q[SEL_LO_BIT];
  wire [1:0] clk_sel = {serial3_clock_sel_hi, serial3_clock_sel_lo};
  wire serial3_async_tx_enable = amode0_q[TX_EN_BIT];
  wire serial3_async_rx_enable = amode0_q[RX_EN_BIT];

  // three-wire mode is the run bit with both uart enables clear
  wire uart_mode    = serial3_async_tx_enable | serial3_async_rx_enable;
  wire clocked_mode = serial3_clocked_run & ~uart_mode;

  wire wr_ctrl   = wr && (addr == CTRL_ADDR);
  wire wr_amode0 = wr && (addr == AMODE0_ADDR);
  wire wr_amode1 = wr && (addr == AMODE1_ADDR);
  wire clear_all = reset | clock_stop;

  wire [3:0] rd_mux = (addr == CTRL_ADDR)   ? ctrl_q   :
                      (addr == ASTAT_ADDR)  ? ZERO_NIB :
                      (addr == AMODE0_ADDR) ? amode0_q :
                      (addr == AMODE1_ADDR) ? amode1_q : ZERO_NIB;

  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      amode0_q <= ZERO_NIB;
      amode1_q <= ZERO_NIB;
    end else begin
      if (wr_amode0) amode0_q <= wdata;
      if (wr_amode1) amode1_q <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata <= ZERO_NIB;
    end else begin
      rdata <= rd ? rd_mux : ZERO_NIB;
    end
  end

  // external shift clock is asynchronous; s1 only feeds s2
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_s3_q <= 1'b1;
    end else begin
      ext_s1_q <= ext_shift_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  serial3_rate_div u_div (
    .core_clk (core_clk),
    .reset    (reset),
    .run      (clocked_mode),
    .sel      (clk_sel),
    .tick     (tick)
  );

  wire use_ext  = (clk_sel == CLK_EXT);
  wire ext_fall = ext_s3_q & ~ext_s2_q;
  wire int_fall = tick & int_clk_q;
  wire edge_d   = clocked_mode & (use_ext ? ext_fall : int_fall);

  // idles high so a stopped link shows no spurious edge
  always_ff @(posedge core_clk) begin
    if (reset || !clocked_mode || use_ext) begin
      int_clk_q <= 1'b1;
    end else if (tick) begin
      int_clk_q <= ~int_clk_q;
    end
  end

  // pin select counts only in three-wire mode; the output enable needs pin set up too
  wire pin_is_data = clocked_mode & serial3_out_pin_select;
  wire pin_ready   = port_b_bit1_direction & port_b_pin1_latch;

  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      serial3_clocked_active <= 1'b0;
      serial3_shift_clk      <= 1'b1;
      serial3_shift_edge     <= 1'b0;
      serial3_data_out       <= 1'b1;
      serial3_data_out_oe    <= 1'b0;
    end else begin
      serial3_clocked_active <= clocked_mode;
      serial3_shift_clk      <= use_ext ? ext_s2_q : int_clk_q;
      serial3_shift_edge     <= edge_d;
      serial3_data_out       <= pin_is_data ? serial3_shift_data : 1'b1;
      serial3_data_out_oe    <= pin_is_data & pin_ready;
    end
  end

  run_clears_a: assert property (@(posedge core_clk) disable iff (reset)
    clock_stop |=> (ctrl_q == CTRL_RESET))
    else $error("control register not cleared by clock stop");
  write_ctrl_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr_ctrl && !clock_stop) |=> (ctrl_q == $past(wdata)))
    else $error("control register write lost");
  read_back_a: assert property (@(posedge core_clk) disable iff (reset)
    (rd && addr == CTRL_ADDR) |=> (rdata == $past(ctrl_q)))
    else $error("control register read mismatch");
  wait_no_edge_a: assert property (@(posedge core_clk) disable iff (reset)
    !clocked_mode |=> !serial3_shift_edge)
    else $error("shift edge while stopped");
  uart_blocks_a: assert property (@(posedge core_clk) disable iff (reset)
    uart_mode |=> !serial3_clocked_active)
    else $error("clocked mode active with uart enabled");
  pin_ignored_a: assert property (@(posedge core_clk) disable iff (reset)
    !clocked_mode |=> !serial3_data_out_oe)
    else $error("data out driven outside three-wire mode");
  pin_setup_a: assert property (@(posedge core_clk) disable iff (reset)
    (pin_is_data && pin_ready && !clock_stop) |=> serial3_data_out_oe)
    else $error("data out not enabled when routed");
  ext_edge_a: assert property (@(posedge core_clk) disable iff (reset)
    (clocked_mode && use_ext && ext_fall && !clock_stop)
      |=> serial3_shift_edge)
    else $error("external clock edge missed");
  int_rate_a: assert property (@(posedge core_clk) disable iff (reset)
    (tick && clocked_mode && !use_ext) |=> !tick [*3])
    else $error("internal divider too fast");
  async_regs_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr_amode1 && !clock_stop) |=> (amode1_q == $past(wdata)))
    else $error("async mode register write lost");

  ext_run_c:  cover property (@(posedge core_clk)
    clocked_mode && use_ext && serial3_shift_edge);
  fast_run_c: cover property (@(posedge core_clk)
    clocked_mode && clk_sel == CLK_FAST && serial3_shift_edge);
  pin_data_c: cover property (@(posedge core_clk) serial3_data_out_oe);
  stop_c:     cover property (@(posedge core_clk)
    serial3_clocked_active ##1 clock_stop);
endmodule
`default_nettype wire

/* File: verif/serial3_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module serial3_peer (
  input  wire logic frame,
  output logic      sck
);
  // clock idles high; once a frame ends it finishes its current period, then stands still
  initial sck = 1'b1;
  always begin
    wait (frame);
    #3;
    while (frame) begin
      #80 sck = 1'b0;
      #80 sck = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verif/serial3_mode_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module serial3_mode_control_tb_top;
  import serial3_pkg::*;
  logic              core_clk = 0;
  logic              reset    = 1;
  logic              stop     = 0;
  logic              wr       = 0;
  logic              rd       = 0;
  logic [ADDR_W-1:0] addr     = 8'h00;
  logic [DATA_W-1:0] wdata    = 4'h0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v;
  logic              dir      = 0;
  logic              latch    = 0;
  logic              sdat     = 1;
  logic              frame    = 0;
  logic              sck;
  logic              active;
  logic              sclk;
  logic              sedge;
  logic              dout;
  logic              oe;
  int                fails    = 0;
  int                n_compared = 0;
  int                edges    = 0;
  int                cnt;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (sedge) edges <= edges + 1;
  serial3_peer serial3_peer_i (.frame(frame), .sck(sck));
  serial3_mode_control serial3_mode_control_i (
    .core_clk(core_clk), .reset(reset), .clock_stop(stop), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_shift_clk(sck), .port_b_bit1_direction(dir),
    .port_b_pin1_latch(latch), .serial3_shift_data(sdat),
    .serial3_clocked_active(active), .serial3_shift_clk(sclk),
    .serial3_shift_edge(sedge), .serial3_data_out(dout),
    .serial3_data_out_oe(oe));
  task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [3:0] d);
    @(posedge core_clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge core_clk);
    wr <= 0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a; rd <= 1;
    @(posedge core_clk);
    rd <= 0;
    @(negedge core_clk);
    v = rdata;
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_regs();
    rd_reg(CTRL_ADDR); chk("ctrl_rst", v, 4'h0);
    chk("idle", {active, sclk, oe, dout}, 4'h5);
    for (int i = 0; i < 16; i++) begin
      wr_reg(CTRL_ADDR, 4'(i));
      rd_reg(CTRL_ADDR); chk("ctrl", v, 4'(i));
    end
    wr_reg(AMODE1_ADDR, 4'hA); rd_reg(AMODE1_ADDR); chk("am1", v, 4'hA);
    rd_reg(ASTAT_ADDR); chk("stat", v, 4'h0);
    wr_reg(8'h55, 4'h3); rd_reg(8'h55); chk("unmap", v, 4'h0);
    rd_reg(CTRL_ADDR); chk("ctrl_keep", v, 4'hF);
  endtask
  task automatic t_mode();
    wr_reg(AMODE0_ADDR, 4'h0);
    wr_reg(CTRL_ADDR, 4'h8); chk("run", active, 1);
    wr_reg(AMODE0_ADDR, 4'h8); chk("tx_blk", active, 0);
    wr_reg(AMODE0_ADDR, 4'h4); chk("rx_blk", active, 0);
    wr_reg(AMODE0_ADDR, 4'h0);
    wr_reg(CTRL_ADDR, 4'h0); chk("wait", active, 0);
  endtask
  task automatic t_pin();
    dir <= 1; latch <= 1; sdat <= 0;
    wr_reg(CTRL_ADDR, 4'hC); chk("oe", {oe, dout}, 4'h2);
    wr_reg(CTRL_ADDR, 4'h8); chk("port", {oe, dout}, 4'h1);
    wr_reg(CTRL_ADDR, 4'hC); wr_reg(AMODE0_ADDR, 4'h8);
    chk("uart_ign", oe, 0);
    wr_reg(AMODE0_ADDR, 4'h0); dir <= 0;
    wr_reg(CTRL_ADDR, 4'hC); chk("dir_off", oe, 0);
  endtask
  task automatic t_clk();
    int   h[3];
    logic prev;
    h = '{MID_HALF, FAST_HALF, SLOW_HALF};
    wr_reg(CTRL_ADDR, 4'h8);
    // edge counter has one driver; measure against a snapshot
    cnt = edges;
    frame <= 1;
    #1200 frame <= 0;
    repeat (30) @(posedge core_clk);
    chk("ext_edges", 4'(edges - cnt), 4'h8);
    for (int s = 1; s < 4; s++) begin
      wr_reg(CTRL_ADDR, 4'h8 | 4'(s));
      // sample the registered clock away from its launching edge
      @(negedge core_clk);
      for (int k = 0; k < 2; k++) begin
        cnt = 0;
        prev = sclk;
        @(negedge core_clk);
        while (sclk === prev && cnt < 3000) begin
          @(negedge core_clk);
          cnt++;
        end
      end
      chk("half", 4'(cnt >= h[s-1] - 1 && cnt <= h[s-1] + 1), 4'h1);
    end
  endtask
  task automatic t_stop();
    wr_reg(CTRL_ADDR, 4'hF);
    @(posedge core_clk) stop <= 1;
    @(posedge core_clk) stop <= 0;
    rd_reg(CTRL_ADDR); chk("stop_clr", v, 4'h0);
    chk("stop_idle", {active, sclk, oe, dout}, 4'h5);
  endtask
  initial begin
    #500_000;
    fails++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 0;
    t_regs();
    t_mode();
    t_pin();
    t_clk();
    t_stop();
    final_report();
  end
endmodule
`default_nettype wire
